// ===== rtl/rac_rename_issue.sv
// Register rename allocation, in-order retire and integer cluster issue
//
// Overview of operation
// RL1 - Take a free register at map; give one back only after retire.
// RL2 - The register returned is the previous mapping of the destination.
// RL3 - Stores, branches, prefetches and zero-register targets take no register.
// RL4 - Retire in program order; a late retire holds back all younger ones.
// RL5 - Branches and stores free nothing but still gate younger releases.
// RL6 - Map-to-release latency per class: 7, 10, 13 and 16 cycles.
// RL7 - Each latency splits into map-to-retire and retire-to-release parts.
// RL8 - Integer file has 80 registers: 39 committed, 41 speculative.
// RL9 - Eight integer spares are held back, leaving 33 for in-flight results.
// RL10 - With 33 integer results in flight a further integer request stalls.
// RL11 - Float file has 72 registers: 31 committed, 41 spare, 37 usable.
// RL12 - With 37 float results in flight a further float request stalls.
// RL13 - Float store retires 3 cycles later than float operate, holding younger.
// RL14 - At most two float operate instructions execute per cycle.
// RL15 - Integer and float pools are separate with independent limits.
// RL16 - Four integer units as clusters 0 and 1, each upper and lower.
// RL17 - Subcluster fixed at decode; cluster chosen at issue.
// RL18 - Results usable next cycle locally, one cycle later in other cluster.
// RL19 - Issue only when operands ready in target cluster; loads ready in both.
// RL20 - Oldest ready instructions win arbitration.
// RL21 - Upper instruction tries cluster 1, then cluster 0.
// RL22 - Lower instruction tries cluster 0, then cluster 1.
// RL23 - The reserve is a fixed count per register file.
`timescale 1ns/1ns
module rac_rename_issue (
    // Clock and reset
    input logic clk,
    input logic rstn,
    // Map group from decode
    input logic [rac_pkg::MAP_W-1:0] map_v,
    input rac_pkg::rac_cls_t [rac_pkg::MAP_W-1:0] map_cls,
    input logic [rac_pkg::MAP_W-1:0][rac_pkg::ARCH_W-1:0] map_dst,
    // Map answer
    output logic map_take_q,
    output logic map_stall_q,
    output logic [rac_pkg::MAP_W-1:0][rac_pkg::TAG_W-1:0] map_new_q,
    output logic [rac_pkg::MAP_W-1:0][rac_pkg::TAG_W-1:0] map_old_q,
    // Room and pool status
    output logic [1:0] int_room_q,
    output logic [1:0] fp_room_q,
    output logic [1:0] rob_room_q,
    output logic [rac_pkg::USE_W-1:0] int_used_q,
    output logic [rac_pkg::USE_W-1:0] fp_used_q,
    output logic [rac_pkg::MAP_W-1:0] retire_q,
    // Integer issue candidates, index 0 oldest
    input logic [rac_pkg::IQ_N-1:0] iq_v,
    input logic [rac_pkg::IQ_N-1:0] iq_up,
    input logic [rac_pkg::IQ_N-1:0][1:0] iq_src_use,
    input logic [rac_pkg::IQ_N-1:0][1:0][rac_pkg::TAG_W-1:0] iq_src,
    input logic [rac_pkg::IQ_N-1:0] iq_dst_v,
    input logic [rac_pkg::IQ_N-1:0][rac_pkg::TAG_W-1:0] iq_dst,
    // Load data return
    input logic ld_v,
    input logic [rac_pkg::TAG_W-1:0] ld_tag,
    // Issue grants
    output logic [rac_pkg::IQ_N-1:0] iss_gnt_q,
    output logic [rac_pkg::IQ_N-1:0] iss_cl_q
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [rac_pkg::ROB_N-1:0] rv;
        logic [rac_pkg::ROB_N-1:0] rfp;
        logic [rac_pkg::ROB_N-1:0] rdst;
        logic [rac_pkg::ROB_N-1:0] rlng;
        logic [rac_pkg::ROB_N-1:0][rac_pkg::TAG_W-1:0] rold;
        logic [rac_pkg::ROB_N-1:0][rac_pkg::CNT_W-1:0] rcnt;
        logic [rac_pkg::PTR_W-1:0] head;
        logic [rac_pkg::PTR_W-1:0] tail;
        logic [rac_pkg::PTR_W:0] used;
        logic [rac_pkg::INT_ARCH_N-1:0][rac_pkg::TAG_W-1:0] imap;
        logic [rac_pkg::FP_ARCH_N-1:0][rac_pkg::TAG_W-1:0] fmap;
        logic [rac_pkg::INT_PHYS-1:0] ifree;
        logic [rac_pkg::FP_PHYS-1:0] ffree;
        logic [rac_pkg::USE_W-1:0] icnt;
        logic [rac_pkg::USE_W-1:0] fcnt;
        logic [1:0][rac_pkg::R2R_LONG-1:0][rac_pkg::MAP_W-1:0] pv;
        logic [1:0][rac_pkg::R2R_LONG-1:0][rac_pkg::MAP_W-1:0] pfp;
        logic [1:0][rac_pkg::R2R_LONG-1:0][rac_pkg::MAP_W-1:0][rac_pkg::TAG_W-1:0] pt;
        logic [1:0][rac_pkg::INT_PHYS-1:0] rdy;
        logic [rac_pkg::IQ_N-1:0] xv;
        logic [rac_pkg::IQ_N-1:0] xc;
        logic [rac_pkg::IQ_N-1:0][rac_pkg::TAG_W-1:0] xt;
        logic take;
        logic stall;
        logic [rac_pkg::MAP_W-1:0][rac_pkg::TAG_W-1:0] newt;
        logic [rac_pkg::MAP_W-1:0][rac_pkg::TAG_W-1:0] oldt;
        logic [1:0] iroom;
        logic [1:0] froom;
        logic [1:0] rroom;
        logic [rac_pkg::MAP_W-1:0] ret;
        logic [rac_pkg::IQ_N-1:0] gnt;
        logic [rac_pkg::IQ_N-1:0] cl;
    } rac_st_t;

    // Committed state fills the low registers, speculative ones start free
    function automatic rac_st_t rst_val();
        rac_st_t s;
        s = '0;
        // RL8 39 committed integer registers
        for (int a = 0; a < rac_pkg::INT_ARCH_N; a++) begin
            if (a < int'(rac_pkg::INT_ZERO)) begin
                s.imap[a] = rac_pkg::rac_tag_t'(a);
            end else if (a >= rac_pkg::SHADOW_BASE) begin
                s.imap[a] = rac_pkg::rac_tag_t'(a - 1);
            end
        end
        // RL11 31 committed float registers
        for (int a = 0; a < rac_pkg::FP_COMMIT; a++) begin
            s.fmap[a] = rac_pkg::rac_tag_t'(a);
        end
        for (int p = rac_pkg::INT_COMMIT; p < rac_pkg::INT_PHYS; p++) begin
            s.ifree[p] = 1'b1;
        end
        for (int p = rac_pkg::FP_COMMIT; p < rac_pkg::FP_PHYS; p++) begin
            s.ffree[p] = 1'b1;
        end
        s.rdy = '1;
        s.iroom = rac_pkg::rac_room_t'(rac_pkg::MAP_W);
        s.froom = rac_pkg::rac_room_t'(rac_pkg::MAP_W);
        s.rroom = rac_pkg::rac_room_t'(rac_pkg::MAP_W);
        return s;
    endfunction

    localparam rac_st_t ST_RST = rst_val();

    rac_st_t st_q;
    rac_st_t st_d;
    logic [rac_pkg::IQ_N-1:0] rdy_c0;
    logic [rac_pkg::IQ_N-1:0] rdy_c1;
    logic [rac_pkg::IQ_N-1:0] gnt_c;
    logic [rac_pkg::IQ_N-1:0] cl_c;

    // ************************************************************
    // Operand readiness per cluster
    // ************************************************************
    always_comb begin
        for (int i = 0; i < rac_pkg::IQ_N; i++) begin
            rdy_c0[i] = 1'b1;
            rdy_c1[i] = 1'b1;
            // RL19 ready in the target cluster
            for (int o = 0; o < 2; o++) begin
                if (iq_src_use[i][o]) begin
                    rdy_c0[i] = rdy_c0[i] && st_q.rdy[0][iq_src[i][o]];
                    rdy_c1[i] = rdy_c1[i] && st_q.rdy[1][iq_src[i][o]];
                end
            end
        end
    end

    // RL17 cluster picked here, subcluster comes in from decode
    rac_steer u_steer (
        .cand_v(iq_v),
        .cand_up(iq_up),
        .rdy_c0(rdy_c0),
        .rdy_c1(rdy_c1),
        .gnt(gnt_c),
        .cl(cl_c)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        int nret;
        int nmap;
        int ireq;
        int freq;
        int nv;
        int irel;
        int frel;
        int ial;
        int fal;
        int room;
        logic stop;
        logic got;
        logic wr;
        logic fp;
        rac_pkg::rac_ptr_t ix;
        rac_pkg::rac_tag_t tg;
        rac_pkg::rac_tag_t old;
        nret = 0;
        nmap = 0;
        ireq = 0;
        freq = 0;
        nv = 0;
        irel = 0;
        frel = 0;
        ial = 0;
        fal = 0;
        room = 0;
        stop = 1'b0;
        got = 1'b0;
        wr = 1'b0;
        fp = 1'b0;
        ix = '0;
        tg = '0;
        old = '0;
        st_d = st_q;
        st_d.take = 1'b0;
        st_d.stall = 1'b0;
        st_d.ret = '0;

        // Release pipes: stage 0 frees, the rest move down
        for (int p = 0; p < 2; p++) begin
            for (int l = 0; l < rac_pkg::MAP_W; l++) begin
                if (st_q.pv[p][0][l] && st_q.pfp[p][0][l]) begin
                    st_d.ffree[st_q.pt[p][0][l]] = 1'b1;
                    frel++;
                end else if (st_q.pv[p][0][l]) begin
                    st_d.ifree[st_q.pt[p][0][l]] = 1'b1;
                    irel++;
                end
            end
            st_d.pv[p] = st_q.pv[p] >> rac_pkg::MAP_W;
            st_d.pfp[p] = st_q.pfp[p] >> rac_pkg::MAP_W;
            st_d.pt[p] = st_q.pt[p] >> (rac_pkg::MAP_W * rac_pkg::TAG_W);
        end

        // RL7 map-to-retire countdown
        for (int e = 0; e < rac_pkg::ROB_N; e++) begin
            if (st_q.rv[e] && (st_q.rcnt[e] != '0)) begin
                st_d.rcnt[e] = st_q.rcnt[e] - rac_pkg::rac_cnt_t'(1);
            end
        end

        // RL4 retire from the head only, stop at first not ready
        for (int r = 0; r < rac_pkg::MAP_W; r++) begin
            ix = st_q.head + rac_pkg::rac_ptr_t'(r);
            if (!stop && st_q.rv[ix] && (st_q.rcnt[ix] == '0)) begin
                st_d.rv[ix] = 1'b0;
                st_d.ret[r] = 1'b1;
                nret++;
                // RL5 no-result entries only advance the head
                // RL2 old mapping goes to the release pipe
                if (st_q.rdst[ix] && st_q.rlng[ix]) begin
                    st_d.pv[1][rac_pkg::R2R_LONG-1][r] = 1'b1;
                    st_d.pfp[1][rac_pkg::R2R_LONG-1][r] = st_q.rfp[ix];
                    st_d.pt[1][rac_pkg::R2R_LONG-1][r] = st_q.rold[ix];
                end else if (st_q.rdst[ix]) begin
                    st_d.pv[0][rac_pkg::R2R_SHORT-1][r] = 1'b1;
                    st_d.pfp[0][rac_pkg::R2R_SHORT-1][r] = st_q.rfp[ix];
                    st_d.pt[0][rac_pkg::R2R_SHORT-1][r] = st_q.rold[ix];
                end
            end else begin
                stop = 1'b1;
            end
        end
        st_d.head = st_q.head + rac_pkg::rac_ptr_t'(nret);

        // RL15 separate demand per pool
        for (int k = 0; k < rac_pkg::MAP_W; k++) begin
            if (map_v[k]) begin
                nv++;
                if (rac_pkg::writes(map_cls[k], map_dst[k]) && rac_pkg::is_fp(map_cls[k])) begin
                    freq++;
                end else if (rac_pkg::writes(map_cls[k], map_dst[k])) begin
                    ireq++;
                end
            end
        end

        // RL10 integer stall
        // RL12 float stall
        if ((nv > 0) && (ireq <= int'(st_q.iroom)) && (freq <= int'(st_q.froom)) &&
            (nv <= int'(st_q.rroom))) begin
            st_d.take = 1'b1;
        end
        st_d.stall = (nv > 0) && !st_d.take;

        // RL14 group width caps float operates at two per cycle
        for (int k = 0; k < rac_pkg::MAP_W; k++) begin
            if (st_d.take && map_v[k]) begin
                ix = st_q.tail + rac_pkg::rac_ptr_t'(nmap);
                nmap++;
                // RL3 no register without a result
                wr = rac_pkg::writes(map_cls[k], map_dst[k]);
                fp = rac_pkg::is_fp(map_cls[k]);
                st_d.rv[ix] = 1'b1;
                st_d.rfp[ix] = fp;
                st_d.rdst[ix] = wr;
                // RL6 per-class latency
                // RL13 float store retires later
                st_d.rcnt[ix] = rac_pkg::rac_cnt_t'(rac_pkg::m2r(map_cls[k]) - 1);
                st_d.rlng[ix] = rac_pkg::long_rel(map_cls[k]);
                st_d.rold[ix] = '0;
                st_d.newt[k] = '0;
                st_d.oldt[k] = '0;
                got = 1'b0;
                // RL1 take the lowest free register
                if (wr && fp) begin
                    for (int p = 0; p < rac_pkg::FP_PHYS; p++) begin
                        if (!got && st_d.ffree[p]) begin
                            got = 1'b1;
                            tg = rac_pkg::rac_tag_t'(p);
                        end
                    end
                    old = st_d.fmap[map_dst[k]];
                    st_d.ffree[tg] = 1'b0;
                    st_d.fmap[map_dst[k]] = tg;
                    fal++;
                end else if (wr) begin
                    for (int p = 0; p < rac_pkg::INT_PHYS; p++) begin
                        if (!got && st_d.ifree[p]) begin
                            got = 1'b1;
                            tg = rac_pkg::rac_tag_t'(p);
                        end
                    end
                    old = st_d.imap[map_dst[k]];
                    st_d.ifree[tg] = 1'b0;
                    st_d.imap[map_dst[k]] = tg;
                    st_d.rdy[0][tg] = 1'b0;
                    st_d.rdy[1][tg] = 1'b0;
                    ial++;
                end
                if (wr) begin
                    st_d.rold[ix] = old;
                    st_d.newt[k] = tg;
                    st_d.oldt[k] = old;
                end
            end
        end
        st_d.tail = st_q.tail + rac_pkg::rac_ptr_t'(nmap);
        st_d.used = rac_pkg::rac_fill_t'(int'(st_q.used) + nmap - nret);
        st_d.icnt = rac_pkg::rac_use_t'(int'(st_q.icnt) + ial - irel);
        st_d.fcnt = rac_pkg::rac_use_t'(int'(st_q.fcnt) + fal - frel);

        // RL9 reserve left out of the room
        // RL23 fixed reserve count
        room = rac_pkg::INT_LIMIT - int'(st_d.icnt);
        st_d.iroom = rac_pkg::rac_room_t'((room > rac_pkg::MAP_W) ? rac_pkg::MAP_W : room);
        room = rac_pkg::FP_LIMIT - int'(st_d.fcnt);
        st_d.froom = rac_pkg::rac_room_t'((room > rac_pkg::MAP_W) ? rac_pkg::MAP_W : room);
        room = rac_pkg::ROB_N - int'(st_d.used);
        st_d.rroom = rac_pkg::rac_room_t'((room > rac_pkg::MAP_W) ? rac_pkg::MAP_W : room);

        // RL18 other cluster sees the result one cycle later
        for (int i = 0; i < rac_pkg::IQ_N; i++) begin
            if (st_q.xv[i]) begin
                st_d.rdy[st_q.xc[i]][st_q.xt[i]] = 1'b1;
            end
        end
        // RL19 loaded values ready in both clusters at once
        if (ld_v) begin
            st_d.rdy[0][ld_tag] = 1'b1;
            st_d.rdy[1][ld_tag] = 1'b1;
        end
        // RL18 producing cluster sees it next cycle
        for (int i = 0; i < rac_pkg::IQ_N; i++) begin
            st_d.gnt[i] = gnt_c[i];
            st_d.cl[i] = cl_c[i];
            st_d.xv[i] = gnt_c[i] && iq_dst_v[i];
            st_d.xc[i] = !cl_c[i];
            st_d.xt[i] = iq_dst[i];
            if (gnt_c[i] && iq_dst_v[i]) begin
                st_d.rdy[cl_c[i]][iq_dst[i]] = 1'b1;
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign map_take_q = st_q.take;
    assign map_stall_q = st_q.stall;
    assign map_new_q = st_q.newt;
    assign map_old_q = st_q.oldt;
    assign int_room_q = st_q.iroom;
    assign fp_room_q = st_q.froom;
    assign rob_room_q = st_q.rroom;
    assign int_used_q = st_q.icnt;
    assign fp_used_q = st_q.fcnt;
    assign retire_q = st_q.ret;
    assign iss_gnt_q = st_q.gnt;
    assign iss_cl_q = st_q.cl;

endmodule

// ===== include/rac_pkg.sv
// Shared constants, types and class helpers for the rename and issue block
package rac_pkg;

    // ************************************************************
    // Widths and depths
    // ************************************************************
    localparam int MAP_W = 2;
    localparam int ROB_N = 16;
    localparam int IQ_N = 4;
    localparam int TAG_W = 7;
    localparam int ARCH_W = 6;
    localparam int CNT_W = 4;
    localparam int USE_W = 6;
    localparam int PTR_W = 4;

    // ************************************************************
    // Register files
    // ************************************************************
    localparam int INT_PHYS = 80;
    localparam int FP_PHYS = 72;
    localparam int INT_COMMIT = 39;
    localparam int FP_COMMIT = 31;
    localparam int INT_SPEC = INT_PHYS - INT_COMMIT;
    localparam int FP_SPEC = FP_PHYS - FP_COMMIT;
    localparam int INT_RSV = 8;
    localparam int FP_RSV = 4;
    localparam int INT_LIMIT = INT_SPEC - INT_RSV;
    localparam int FP_LIMIT = FP_SPEC - FP_RSV;
    localparam int INT_ARCH_N = 40;
    localparam int FP_ARCH_N = 32;
    localparam int SHADOW_BASE = 32;
    localparam logic [ARCH_W-1:0] INT_ZERO = 6'h1f;
    localparam logic [ARCH_W-1:0] FP_ZERO = 6'h1f;

    // ************************************************************
    // Map-to-retire and retire-to-release latencies
    // ************************************************************
    localparam int M2R_INT_OP = 5;
    localparam int M2R_INT_MEM = 8;
    localparam int M2R_FP_OP = 9;
    localparam int M2R_FP_LD = 8;
    localparam int FP_ST_EXTRA = 3;
    localparam int M2R_FP_ST = M2R_FP_OP + FP_ST_EXTRA;
    localparam int R2R_SHORT = 2;
    localparam int R2R_LONG = 4;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic [TAG_W-1:0] rac_tag_t;
    typedef logic [CNT_W-1:0] rac_cnt_t;
    typedef logic [USE_W-1:0] rac_use_t;
    typedef logic [PTR_W-1:0] rac_ptr_t;
    typedef logic [PTR_W:0] rac_fill_t;
    typedef logic [1:0] rac_room_t;

    typedef enum logic [2:0] {
        CL_INT_OP = 3'h0,
        CL_INT_LD = 3'h1,
        CL_INT_ST = 3'h2,
        CL_INT_BR = 3'h3,
        CL_FP_OP = 3'h4,
        CL_FP_LD = 3'h5,
        CL_FP_ST = 3'h6,
        CL_PREF = 3'h7
    } rac_cls_t;

    function automatic logic is_fp(rac_cls_t c);
        return (c == CL_FP_OP) || (c == CL_FP_LD) || (c == CL_FP_ST);
    endfunction

    function automatic logic writes(rac_cls_t c, logic [ARCH_W-1:0] dst);
        return (((c == CL_INT_OP) || (c == CL_INT_LD)) && (dst != INT_ZERO)) ||
               (((c == CL_FP_OP) || (c == CL_FP_LD)) && (dst != FP_ZERO));
    endfunction

    function automatic int m2r(rac_cls_t c);
        unique case (c)
            CL_INT_OP, CL_INT_BR: return M2R_INT_OP;
            CL_INT_LD, CL_INT_ST, CL_PREF: return M2R_INT_MEM;
            CL_FP_OP: return M2R_FP_OP;
            CL_FP_LD: return M2R_FP_LD;
            CL_FP_ST: return M2R_FP_ST;
        endcase
    endfunction

    function automatic logic long_rel(rac_cls_t c);
        return (c == CL_FP_OP) || (c == CL_FP_ST);
    endfunction

endpackage

// ===== rtl/rac_steer.sv
// Oldest-first cluster steering of integer issue candidates
`timescale 1ns/1ns
module rac_steer (
    // Candidates, index 0 oldest
    input logic [rac_pkg::IQ_N-1:0] cand_v,
    input logic [rac_pkg::IQ_N-1:0] cand_up,
    input logic [rac_pkg::IQ_N-1:0] rdy_c0,
    input logic [rac_pkg::IQ_N-1:0] rdy_c1,
    // Grants
    output logic [rac_pkg::IQ_N-1:0] gnt,
    output logic [rac_pkg::IQ_N-1:0] cl
);

    // ************************************************************
    // Unit arbitration
    // ************************************************************
    always_comb begin
        logic [1:0] busy_up;
        logic [1:0] busy_lo;
        logic [1:0] ok;
        logic first;
        busy_up = '0;
        busy_lo = '0;
        ok = '0;
        first = 1'b0;
        gnt = '0;
        cl = '0;
        // RL20 oldest served first
        for (int i = 0; i < rac_pkg::IQ_N; i++) begin
            // RL19 data ready only
            ok[0] = cand_v[i] && rdy_c0[i] && !(cand_up[i] ? busy_up[0] : busy_lo[0]);
            ok[1] = cand_v[i] && rdy_c1[i] && !(cand_up[i] ? busy_up[1] : busy_lo[1]);
            // RL21 upper prefers cluster 1
            // RL22 lower prefers cluster 0
            first = cand_up[i];
            if (ok[first]) begin
                gnt[i] = 1'b1;
                cl[i] = first;
            end else if (ok[!first]) begin
                gnt[i] = 1'b1;
                cl[i] = !first;
            end
            // RL16 two clusters, upper and lower unit each
            if (gnt[i] && cand_up[i]) begin
                busy_up[cl[i]] = 1'b1;
            end
            if (gnt[i] && !cand_up[i]) begin
                busy_lo[cl[i]] = 1'b1;
            end
        end
    end

endmodule

// ===== verification/rac_props.sv
// Checker of map answers, pool limits, retire order and grants
`timescale 1ns/1ns
module rac_props (
    // Clock and reset
    input logic clk,
    input logic rstn,
    // Map side
    input logic [1:0] map_v,
    input logic map_take_q,
    input logic map_stall_q,
    input logic [5:0] int_used_q,
    input logic [5:0] fp_used_q,
    input logic [1:0] retire_q,
    // Issue side
    input logic [3:0] iq_v,
    input logic [3:0] iss_gnt_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_req;
        |map_v;
    endsequence
    sequence s_answer;
        map_take_q ^ map_stall_q;
    endsequence
    a_map_answer: assert property (s_req |=> s_answer)
        else $error("map group not answered once");
    a_no_spurious: assert property ((map_take_q || map_stall_q) |-> $past(|map_v))
        else $error("map answer without request");
    a_int_limit: assert property (int_used_q <= 6'h21)
        else $error("integer pool above limit");
    a_fp_limit: assert property (fp_used_q <= 6'h25)
        else $error("float pool above limit");
    a_alloc_take: assert property ((int_used_q > $past(int_used_q)) |-> map_take_q)
        else $error("integer register taken without map");
    a_fp_step: assert property (fp_used_q <= $past(fp_used_q) + 6'h02)
        else $error("float pool grew too fast");
    a_retire_order: assert property (retire_q[1] |-> retire_q[0])
        else $error("younger lane retired alone");
    a_grant_cause: assert property ((iss_gnt_q & ~$past(iq_v)) == 4'h0)
        else $error("grant without candidate");
    a_int_release: assert property ((int_used_q < $past(int_used_q)) |-> $past(retire_q, 2) != 2'h0)
        else $error("integer release not two after retire");
    a_fp_release: assert property ((fp_used_q < $past(fp_used_q)) |->
        ($past(retire_q, 2) != 2'h0) || ($past(retire_q, 4) != 2'h0))
        else $error("float release without retire");
endmodule
bind rac_rename_issue rac_props u_props (.clk(clk), .rstn(rstn), .map_v(map_v), .map_take_q(map_take_q),
    .map_stall_q(map_stall_q), .int_used_q(int_used_q), .fp_used_q(fp_used_q), .retire_q(retire_q),
    .iq_v(iq_v), .iss_gnt_q(iss_gnt_q));

// ===== verification/rac_fe_model.sv
// Decode model: offers a map group for one edge, re-offers it when refused
`timescale 1ns/1ns
module rac_fe_model (
    // Clock and reset
    input logic clk,
    input logic rstn,
    // Bench request
    input logic go,
    input logic [1:0] go_v,
    input rac_pkg::rac_cls_t [1:0] go_cls,
    input logic [1:0][5:0] go_dst,
    // Map group
    output logic [1:0] map_v,
    output rac_pkg::rac_cls_t [1:0] map_cls,
    output logic [1:0][5:0] map_dst,
    input logic map_stall_q
);
    logic [1:0] v_q;
    logic [1:0][5:0] dst_q;
    // Destination fields flip while nothing is offered
    assign map_dst = (|map_v) ? dst_q : ~dst_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            map_v <= 2'h0;
            v_q <= 2'h0;
            dst_q <= 12'h000;
        end else if (|map_v) begin
            map_v <= 2'h0;
        end else if (map_stall_q) begin
            map_v <= v_q;
        end else if (go) begin
            map_v <= go_v;
            v_q <= go_v;
            map_cls <= go_cls;
            dst_q <= go_dst;
        end
    end
endmodule

// ===== verification/testbench.sv
// Bench for rename allocation, in-order retire and cluster issue
`timescale 1ns/1ns
module testbench;
    logic clk, rstn, go, tk, st, ld_v;
    logic [1:0] go_v, map_v, rtq, ir, fr, rr;
    rac_pkg::rac_cls_t [1:0] go_cls, map_cls;
    logic [1:0][5:0] go_dst, map_dst;
    logic [1:0][6:0] nw, od;
    logic [5:0] iu, fu;
    logic [3:0] iq_v, iq_up, iq_dst_v, gnt, cl;
    logic [3:0][1:0] iq_src_use;
    logic [3:0][1:0][6:0] iq_src;
    logic [3:0][6:0] iq_dst;
    logic [6:0] ld_tag;
    int n_fail, cmp_count, k;
    int rt[8] = '{5, 8, 8, 5, 9, 8, 12, 8};
    int rl[8] = '{7, 10, 0, 0, 13, 10, 0, 0};
    logic [6:0] en[8] = '{7'h27, 7'h01, 7'h00, 7'h00, 7'h1f, 7'h01, 7'h00, 7'h00};
    logic [6:0] eo[8] = '{7'h01, 7'h27, 7'h00, 7'h00, 7'h01, 7'h1f, 7'h00, 7'h00};
    rac_fe_model u_rac_fe_model (.clk(clk), .rstn(rstn), .go(go), .go_v(go_v), .go_cls(go_cls),
        .go_dst(go_dst), .map_v(map_v), .map_cls(map_cls), .map_dst(map_dst), .map_stall_q(st));
    rac_rename_issue u_rac_rename_issue (.clk(clk), .rstn(rstn), .map_v(map_v), .map_cls(map_cls),
        .map_dst(map_dst), .map_take_q(tk), .map_stall_q(st), .map_new_q(nw), .map_old_q(od),
        .int_room_q(ir), .fp_room_q(fr), .rob_room_q(rr), .int_used_q(iu), .fp_used_q(fu), .retire_q(rtq),
        .iq_v(iq_v), .iq_up(iq_up), .iq_src_use(iq_src_use), .iq_src(iq_src), .iq_dst_v(iq_dst_v),
        .iq_dst(iq_dst), .ld_v(ld_v), .ld_tag(ld_tag), .iss_gnt_q(gnt), .iss_cl_q(cl));
    task automatic close_out;
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Values read in the active region of an edge are those of the cycle it ends
    task automatic map(logic [1:0] v, rac_pkg::rac_cls_t c0, c1, logic [5:0] d0, d1);
        go <= 1'b1;
        go_v <= v;
        go_cls[0] <= c0;
        go_cls[1] <= c1;
        go_dst <= {d1, d0};
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 20 && tk !== 1'b1; i++) @(posedge clk);
        if (tk !== 1'b1) begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic trace(int rtc, logic [1:0] rtv, int irel, int frel);
        for (int j = 1; j <= 16; j++) begin
            @(posedge clk);
            chk("retire", {st, tk, rtq}, (j == rtc) ? rtv : 2'h0);
            chk("int_used", iu, j < irel);
            chk("fp_used", fu, j < frel);
        end
    endtask
    task automatic iss(logic [3:0] v, up, logic [6:0] s0, d0, ld, logic [3:0] eg, ec);
        iq_v <= v;
        iq_up <= up;
        iq_src_use <= {7'h00, s0 != 7'h00};
        iq_src <= {49'h0, s0};
        iq_dst_v <= {3'h0, d0 != 7'h00};
        iq_dst <= {21'h0, d0};
        ld_v <= ld != 7'h00;
        ld_tag <= ld;
        @(posedge clk);
        chk("grant", gnt, eg);
        chk("cluster", cl & gnt, ec);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        n_fail = 0;
        cmp_count = 0;
        rstn = 1'b0;
        go = 1'b0;
        go_v = 2'h0;
        go_cls[0] = rac_pkg::CL_INT_OP;
        go_cls[1] = rac_pkg::CL_INT_OP;
        go_dst = 12'h000;
        iq_v = 4'h0;
        iq_up = 4'h0;
        iq_src_use = 8'h00;
        iq_src = 56'h0;
        iq_dst_v = 4'h0;
        iq_dst = 28'h0;
        ld_v = 1'b0;
        ld_tag = 7'h00;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("rooms", {2'h0, ir, fr, rr}, 8'h2a);
        for (k = 0; k < 8; k++) begin
            map(2'h1, rac_pkg::rac_cls_t'(k), rac_pkg::CL_INT_OP, 6'h01, 6'h00);
            chk("new_tag", nw[0], en[k]);
            chk("old_tag", od[0], eo[k]);
            trace(rt[k], 2'h1, (k >= 4 && k <= 6) ? 0 : rl[k], (k >= 4 && k <= 6) ? rl[k] : 0);
        end
        // Float store at the head holds back the younger integer result
        map(2'h3, rac_pkg::CL_FP_ST, rac_pkg::CL_INT_OP, 6'h01, 6'h02);
        trace(12, 2'h3, 14, 0);
        iss(4'hf, 4'hf, 7'h00, 7'h00, 7'h00, 4'h0, 4'h0);
        iss(4'hf, 4'h0, 7'h00, 7'h00, 7'h00, 4'h3, 4'h1);
        iss(4'h1, 4'h1, 7'h27, 7'h00, 7'h00, 4'h3, 4'h2);
        iss(4'h0, 4'h0, 7'h00, 7'h00, 7'h27, 4'h0, 4'h0);
        iss(4'h1, 4'h1, 7'h27, 7'h00, 7'h00, 4'h0, 4'h0);
        iss(4'h1, 4'h0, 7'h00, 7'h01, 7'h00, 4'h1, 4'h1);
        iss(4'h1, 4'h1, 7'h01, 7'h00, 7'h00, 4'h1, 4'h0);
        iss(4'h1, 4'h1, 7'h01, 7'h00, 7'h00, 4'h1, 4'h0);
        iss(4'h0, 4'h0, 7'h00, 7'h00, 7'h00, 4'h1, 4'h1);
        close_out();
    end
endmodule
